// ===== dv/lpcsm_clock_mux_chk.sv
// Port checker of the line port clock source mux
module lpcsm_clock_mux_chk
  import lpcsm_pkg::*;
#(
  parameter int LOSS_CYCLES = LOSS_CYC
) (
  // Clock, reset and register writes
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  // Clock sources
  input wire logic rx_recovered_clock_in,
  input wire logic rx_line_clock_in,
  input wire logic clock_rate_adapter_in,
  input wire logic tx_clock_in,
  // Outputs
  input wire logic tx_line_clock_out,
  input wire logic tx_clock_out,
  input wire logic rx_clock_out,
  input wire logic tx_framer_data_taken,
  input wire logic rx_line_data_taken
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] c3_r;
  logic [5:0] c4_r;
  logic [5:0] q_r;
  logic lt, ch, act, ok;
  logic [2:0] lb;
  assign lt = c3_r[0];
  assign ch = c3_r[1];
  assign lb = c4_r[5:3];
  assign act = (c4_r[2:0] != 3'h0) && !c4_r[2];
  // Switching ends well inside 63 cycles, so checks wait that long
  assign ok = (q_r == 6'h3f);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      c3_r <= 2'h0;
    else if (reg_write && reg_addr == ADDR_CFG3)
      c3_r <= reg_wdata[1:0];
  end
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      c4_r <= 6'h00;
    else if (reg_write && reg_addr == ADDR_CFG4)
      c4_r <= {reg_wdata[6:4], reg_wdata[2:0]};
  end
  always_ff @(posedge sys_clk)
  begin
    if (reset || (reg_write
        && (reg_addr == ADDR_CFG3 || reg_addr == ADDR_CFG4)))
      q_r <= 6'h00;
    else if (!ok)
      q_r <= q_r + 6'h01;
  end
  property p_loop_same;
    ok && lt |-> tx_clock_out == rx_clock_out
      && tx_line_clock_out == rx_clock_out;
  endproperty
  a_loop_same: assert property (p_loop_same) else $error("loop clocks differ");
  property p_loop_act;
    ok && lt && act |-> rx_clock_out == $past(rx_recovered_clock_in, 3);
  endproperty
  a_loop_act: assert property (p_loop_act) else $error("rx not recovered");
  property p_rx_line;
    ok && !act && (lt || (!lb[2] && !(lb == 3'h1 && ch)))
      |-> rx_clock_out == $past(rx_line_clock_in, 3);
  endproperty
  a_rx_line: assert property (p_rx_line) else $error("rx not line pin");
  property p_llb;
    ok && !lt && act && (lb == 3'h2 || lb == 3'h6)
      |-> tx_line_clock_out == $past(rx_recovered_clock_in, 3);
  endproperty
  a_llb: assert property (p_llb) else $error("line clock wrong");
  property p_plb;
    ok && !lt && lb == 3'h3 |-> tx_clock_out == rx_clock_out;
  endproperty
  a_plb: assert property (p_plb) else $error("payload tx clock wrong");
  property p_dlb;
    ok && !lt && lb[2] && ch |-> rx_clock_out == $past(tx_clock_in, 3);
  endproperty
  a_dlb: assert property (p_dlb) else $error("diag rx clock wrong");
  property p_def_tx;
    ok && !lt && lb != 3'h3 && !ch
      |-> tx_clock_out == $past(clock_rate_adapter_in, 3);
  endproperty
  a_def_tx: assert property (p_def_tx) else $error("tx not adapter");
  property p_tl_def;
    ok && !lt && ch && lb != 3'h2 && lb != 3'h3 && lb != 3'h6
      |-> tx_line_clock_out == $past(tx_clock_in, 3);
  endproperty
  a_tl_def: assert property (p_tl_def) else $error("tl not tx pin");
  property p_plb_data;
    ok && lb == 3'h3 |-> !tx_framer_data_taken;
  endproperty
  a_plb_data: assert property (p_plb_data) else $error("tx data taken");
  property p_dlb_data;
    ok && lb[2] |-> !rx_line_data_taken;
  endproperty
  a_dlb_data: assert property (p_dlb_data) else $error("rx data taken");
  property p_runt;
    $rose(rx_clock_out) |=> rx_clock_out[*2];
  endproperty
  a_runt: assert property (p_runt) else $error("runt pulse");
  c_loop: cover property (ok && lt && act);
  c_both: cover property (ok && !lt && lb == 3'h6);
  c_plb: cover property (ok && !lt && lb == 3'h3);
endmodule

bind lpcsm_clock_mux lpcsm_clock_mux_chk #(.LOSS_CYCLES(LOSS_CYCLES)) i_chk (
  .sys_clk, .reset, .reg_addr, .reg_wdata, .reg_write,
  .rx_recovered_clock_in, .rx_line_clock_in, .clock_rate_adapter_in,
  .tx_clock_in, .tx_line_clock_out, .tx_clock_out, .rx_clock_out,
  .tx_framer_data_taken, .rx_line_data_taken
);

// ===== dv/lpcsm_line_model.sv
// Far-side model: four free-running clock sources and the line data
module lpcsm_line_model (
  // Sources and line data
  output logic rx_recovered_clock_in,
  output logic rx_line_clock_in,
  output logic clock_rate_adapter_in,
  output logic tx_clock_in,
  output logic rx_line_data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Distinct periods let the bench tell sources apart
  initial
  begin
    rx_recovered_clock_in = 1'b0;
    rx_line_clock_in = 1'b0;
    clock_rate_adapter_in = 1'b0;
    tx_clock_in = 1'b0;
    rx_line_data_in = 1'b1;
  end
  always #240 rx_recovered_clock_in = ~rx_recovered_clock_in;
  always #160 rx_line_clock_in = ~rx_line_clock_in;
  always #320 clock_rate_adapter_in = ~clock_rate_adapter_in;
  always #400 tx_clock_in = ~tx_clock_in;
endmodule

// ===== dv/tb_line_port_clock_source_mux.sv
// Testbench of the line port clock source mux
module tb_line_port_clock_source_mux;
  timeunit 1ns;
  timeprecision 100ps;
  import lpcsm_pkg::*;
  typedef struct packed {
    logic [4:0] c3;
    logic [6:0] c4;
    logic [6:0] st;
  } lpcsm_row_t;
  logic sys_clk, reset, reg_write, reg_read, tx_framer_data_in;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_v;
  logic rx_recovered_clock_in, rx_line_clock_in, clock_rate_adapter_in;
  logic tx_clock_in, rx_line_data_in, tx_line_clock_out, tx_clock_out;
  logic rx_clock_out, tx_framer_data_taken, rx_line_data_taken;
  logic rx_framer_timing_select, tx_line_timing_select;
  logic tx_framer_timing_select;
  logic [2:0] outs, prev;
  int fails, num_checks, cyc;
  int per [3];
  int cnt [3];
  // Sampled period in cycles of each source code
  logic [11:0] pt [4] = '{12'h00c, 12'h008, 12'h010, 12'h014};
  // Status is {unit active, tl, tx, rx source}
  lpcsm_row_t rows [11] = '{
    '{5'h00, 7'h00, 7'h29}, '{5'h02, 7'h01, 7'h7c}, '{5'h03, 7'h62, 7'h40},
    '{5'h05, 7'h34, 7'h15}, '{5'h10, 7'h23, 7'h48}, '{5'h02, 7'h30, 7'h15},
    '{5'h08, 7'h42, 7'h6a}, '{5'h02, 7'h60, 7'h1f}, '{5'h02, 7'h10, 7'h3f},
    '{5'h1c, 7'h77, 7'h2a}, '{5'h02, 7'h55, 7'h3f}};
  assign outs = {tx_line_clock_out, tx_clock_out, rx_clock_out};
  lpcsm_clock_mux #(.LOSS_CYCLES(20)) i_dut (
    .sys_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .rx_recovered_clock_in, .rx_line_clock_in,
    .clock_rate_adapter_in, .tx_clock_in, .tx_line_clock_out, .tx_clock_out,
    .rx_clock_out, .tx_framer_data_in, .rx_line_data_in,
    .tx_framer_data_taken, .rx_line_data_taken, .rx_framer_timing_select,
    .tx_line_timing_select, .tx_framer_timing_select);
  lpcsm_line_model i_line (.rx_recovered_clock_in, .rx_line_clock_in,
    .clock_rate_adapter_in, .tx_clock_in, .rx_line_data_in);
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [11:0] e,
    input logic [11:0] s);
    num_checks++;
    if (s !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Periods measured on the falling edge, where outputs have settled
  always @(negedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      close_out();
    end
    for (int k = 0; k < 3; k++)
    begin
      cnt[k]++;
      if (outs[k] && !prev[k])
      begin
        per[k] = cnt[k];
        cnt[k] = 0;
      end
    end
    prev = outs;
  end
  initial
  begin
    {reset, reg_write, reg_read, reg_addr} = {3'h4, 8'h00};
    reg_wdata = 32'h0000_0000;
    tx_framer_data_in = 1'b1;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    rd(ADDR_STATUS, rd_v);
    chk("status", 12'h029, {4'h0, rd_v[7:0]});
    foreach (rows[i])
    begin
      wr(ADDR_CFG3, {27'h0, rows[i].c3});
      wr(ADDR_CFG4, {25'h0, rows[i].c4});
      repeat (100) @(posedge sys_clk);
      rd(ADDR_STATUS, rd_v);
      chk("status", {5'h1e, rows[i].st}, rd_v[11:0]);
      for (int k = 0; k < 3; k++)
        chk("period", pt[rows[i].st[2*k+:2]], per[k][11:0]);
      chk("tx data", {11'h0, rows[i].c4[6:4] != 3'h3},
        {11'h0, tx_framer_data_taken});
      chk("rx data", {11'h0, !rows[i].c4[6]},
        {11'h0, rx_line_data_taken});
      // Timing selects are the levels written to config register three, bits 4:2
      chk("tsel", {9'h0, rows[i].c3[4:2]}, {9'h0, tx_framer_timing_select,
        tx_line_timing_select, rx_framer_timing_select});
    end
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    rd(ADDR_CFG4, rd_v);
    chk("cfg4", 12'h000, rd_v[11:0]);
    // Second source change lands while the first is still draining
    wr(ADDR_CFG4, 32'h0000_0020);
    wr(ADDR_CFG4, 32'h0000_0040);
    repeat (100) @(posedge sys_clk);
    wr(ADDR_STATUS, 32'hffff_ffff);
    wr(8'h0c, 32'hffff_ffff);
    rd(ADDR_STATUS, rd_v);
    chk("status", 12'hf2a, rd_v[11:0]);
    @(posedge sys_clk);
    #1 chk("rdata idle", 12'h000, reg_rdata[11:0]);
    rd(8'h0c, rd_v);
    chk("unmapped", 12'h000, rd_v[11:0]);
    rd(ADDR_CFG3, rd_v);
    chk("cfg3", 12'h000, rd_v[11:0]);
    close_out();
  end
endmodule

// ===== rtl/lpcsm_clock_mux.sv
// Clock source selection for one line port, with its register port
//
// Our own choices: the plain strobed port and the register addresses.
module lpcsm_clock_mux
  import lpcsm_pkg::*;
#(
  parameter int LOSS_CYCLES = LOSS_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Clock sources, asynchronous to sys_clk
  input wire logic rx_recovered_clock_in,
  input wire logic rx_line_clock_in,
  input wire logic clock_rate_adapter_in,
  input wire logic tx_clock_in,
  // Clock outputs
  output logic tx_line_clock_out,
  output logic tx_clock_out,
  output logic rx_clock_out,
  // Data paths that loopbacks silence
  input wire logic tx_framer_data_in,
  input wire logic rx_line_data_in,
  output logic tx_framer_data_taken,
  output logic rx_line_data_taken,
  // Timing select levels for the pin timing logic
  output logic rx_framer_timing_select,
  output logic tx_line_timing_select,
  output logic tx_framer_timing_select
);

  generate
    if (LOSS_CYCLES < 2 || LOSS_CYCLES > 255)
    begin : g_bad_loss
      $error("LOSS_CYCLES must lie in 2..255");
    end
  endgenerate

  // Configuration registers
  logic loop_timing_enable_r;
  logic rate_adapter_clock_choice_r;
  logic [2:0] line_mode_select_r;
  logic [2:0] loopback_mode_select_r;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      loop_timing_enable_r <= CFG_BIT_RESET;
      rate_adapter_clock_choice_r <= CFG_BIT_RESET;
      rx_framer_timing_select <= CFG_BIT_RESET;
      tx_line_timing_select <= CFG_BIT_RESET;
      tx_framer_timing_select <= CFG_BIT_RESET;
    end
    else if (reg_write && reg_addr == ADDR_CFG3)
    begin
      loop_timing_enable_r <= reg_wdata[CFG3_LOOP_TIMING_ENABLE];
      rate_adapter_clock_choice_r <= reg_wdata[CFG3_CHOICE];
      rx_framer_timing_select <= reg_wdata[CFG3_RX_FRAMER_TIMING_SELECT];
      tx_line_timing_select <= reg_wdata[CFG3_TX_LINE_TIMING_SELECT];
      tx_framer_timing_select <= reg_wdata[CFG3_TX_FRAMER_TIMING_SELECT];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      line_mode_select_r <= LM_RESET;
      loopback_mode_select_r <= LBM_RESET;
    end
    else if (reg_write && reg_addr == ADDR_CFG4)
    begin
      line_mode_select_r <= reg_wdata[CFG4_LM_LSB +: 3];
      loopback_mode_select_r <= reg_wdata[CFG4_LBM_LSB +: 3];
    end
  end

  // Source selection
  logic line_unit_active;
  logic diag_on;
  logic [1:0] line_src;
  logic [1:0] tx_norm_src;
  logic [NUM_OUT-1:0][1:0] sel_req;

  assign line_unit_active = unit_active(line_mode_select_r); // R14
  assign diag_on = is_diag(loopback_mode_select_r); // R21

  always_comb
  begin
    line_src = line_unit_active ? SRC_LIU : SRC_RX_LINE_CLOCK_IN; // R12
    tx_norm_src = rate_adapter_clock_choice_r ? SRC_TX_CLOCK_IN : SRC_CLOCK_RATE_ADAPTER; // R13
    if (loop_timing_enable_r)
    begin
      // Loopback code is not looked at here at all
      sel_req[OUT_RX] = line_src; // R2 R3 R4
      sel_req[OUT_TX] = line_src; // R1 R3 R4 R22
      sel_req[OUT_TL] = line_src; // R3 R4
    end
    else
    begin
      if (diag_on)
        sel_req[OUT_RX] = tx_norm_src; // R9 R11 R23
      else if (loopback_mode_select_r == LBM_ANALOG && !line_unit_active
               && rate_adapter_clock_choice_r)
        sel_req[OUT_RX] = SRC_TX_CLOCK_IN; // R23
      else
        sel_req[OUT_RX] = line_src; // R12
      if (loopback_mode_select_r == LBM_PAYLOAD)
        sel_req[OUT_TX] = line_src; // R5 R7 R22
      else
        sel_req[OUT_TX] = tx_norm_src; // R13 R22
      if (loopback_mode_select_r == LBM_LINE
          || loopback_mode_select_r == LBM_DIAG_LINE
          || loopback_mode_select_r == LBM_PAYLOAD)
        sel_req[OUT_TL] = line_src; // R6 R7 R11
      else
        sel_req[OUT_TL] = tx_norm_src; // R15
    end
  end

  // Sampled clock sources, ordered by source code
  logic [NUM_SRC-1:0] src_raw;
  logic [NUM_SRC-1:0] src_sync;

  assign src_raw[SRC_LIU] = rx_recovered_clock_in;
  assign src_raw[SRC_RX_LINE_CLOCK_IN] = rx_line_clock_in;
  assign src_raw[SRC_CLOCK_RATE_ADAPTER] = clock_rate_adapter_in;
  assign src_raw[SRC_TX_CLOCK_IN] = tx_clock_in;

  lpcsm_sync #(
    .WIDTH(NUM_SRC)
  ) u_src_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .din(src_raw),
    .dout(src_sync)
  );

  // One glitch-free selector per output clock
  logic [NUM_OUT-1:0] clk_sel;
  logic [NUM_OUT-1:0][1:0] sel_cur;
  logic [NUM_OUT-1:0] mux_busy;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++)
    begin : g_mux
      lpcsm_glitch_mux #(
        .RESET_SEL(gi == OUT_RX ? SRC_RX_LINE_CLOCK_IN : SRC_CLOCK_RATE_ADAPTER)
      ) u_mux (
        .sys_clk(sys_clk),
        .reset(reset),
        .src_levels(src_sync),
        .sel_req(sel_req[gi]),
        .clk_out(clk_sel[gi]),
        .sel_cur(sel_cur[gi]),
        .busy(mux_busy[gi])
      );
    end
  endgenerate

  // Framer clock outputs are the internal logic clocks themselves
  assign rx_clock_out = clk_sel[OUT_RX]; // R23
  assign tx_clock_out = clk_sel[OUT_TX]; // R22
  assign tx_line_clock_out = clk_sel[OUT_TL];

  // Presence watch: a stopped source shows up before anyone selects it
  logic [NUM_SRC-1:0] src_prev_r;
  logic [NUM_SRC-1:0] src_present;
  logic [NUM_SRC-1:0][CNT_W-1:0] idle_cnt_r;
  localparam logic [CNT_W-1:0] LOSS_LIMIT = CNT_W'(LOSS_CYCLES);

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      src_prev_r <= '0;
    else
      src_prev_r <= src_sync;
  end

  generate
    for (gi = 0; gi < NUM_SRC; gi++)
    begin : g_watch
      always_ff @(posedge sys_clk)
      begin
        if (reset)
          idle_cnt_r[gi] <= LOSS_LIMIT;
        else if (src_sync[gi] && !src_prev_r[gi])
          idle_cnt_r[gi] <= '0;
        else if (idle_cnt_r[gi] != LOSS_LIMIT)
          idle_cnt_r[gi] <= idle_cnt_r[gi] + 1'b1;
      end
      assign src_present[gi] = (idle_cnt_r[gi] != LOSS_LIMIT);
    end
  endgenerate

  // Data gating; inputs come from other clock domains
  logic [1:0] data_sync;

  lpcsm_sync #(
    .WIDTH(2)
  ) u_data_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .din({rx_line_data_in, tx_framer_data_in}),
    .dout(data_sync)
  );

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      tx_framer_data_taken <= 1'b0;
      rx_line_data_taken <= 1'b0;
    end
    else
    begin
      // Loop timing keeps clocks fixed but the data paths still loop
      tx_framer_data_taken <= (loopback_mode_select_r == LBM_PAYLOAD)
                              ? 1'b0 : data_sync[0]; // R8
      rx_line_data_taken <= diag_on ? 1'b0 : data_sync[1]; // R10
    end
  end

  // Register read, data one cycle after the strobe
  logic [31:0] status_word;

  always_comb
  begin
    status_word = RDATA_ZERO;
    status_word[ST_RXSRC_LSB +: 2] = sel_cur[OUT_RX];
    status_word[ST_TXSRC_LSB +: 2] = sel_cur[OUT_TX];
    status_word[ST_TLSRC_LSB +: 2] = sel_cur[OUT_TL];
    status_word[ST_ACTIVE] = line_unit_active;
    status_word[ST_BUSY] = |mux_busy;
    status_word[ST_PRESENT_LSB +: NUM_SRC] = src_present;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      reg_rdata <= RDATA_ZERO;
    else if (reg_read)
    begin
      reg_rdata <= RDATA_ZERO;
      case (reg_addr)
        ADDR_CFG3:
        begin
          reg_rdata[CFG3_LOOP_TIMING_ENABLE] <= loop_timing_enable_r;
          reg_rdata[CFG3_CHOICE] <= rate_adapter_clock_choice_r;
          reg_rdata[CFG3_RX_FRAMER_TIMING_SELECT] <= rx_framer_timing_select;
          reg_rdata[CFG3_TX_LINE_TIMING_SELECT] <= tx_line_timing_select;
          reg_rdata[CFG3_TX_FRAMER_TIMING_SELECT] <= tx_framer_timing_select;
        end
        ADDR_CFG4:
        begin
          reg_rdata[CFG4_LM_LSB +: 3] <= line_mode_select_r;
          reg_rdata[CFG4_LBM_LSB +: 3] <= loopback_mode_select_r;
        end
        ADDR_STATUS:
          reg_rdata <= status_word;
        default:
          reg_rdata <= RDATA_ZERO;
      endcase
    end
    else
      reg_rdata <= RDATA_ZERO;
  end

endmodule

// ===== rtl/lpcsm_glitch_mux.sv
// Glitch-free selector of one sampled clock among the four sources
module lpcsm_glitch_mux
  import lpcsm_pkg::*;
#(
  parameter logic [1:0] RESET_SEL = SRC_RX_LINE_CLOCK_IN
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Sampled source levels and wanted source
  input wire logic [NUM_SRC-1:0] src_levels,
  input wire logic [1:0] sel_req,
  // Selected clock and state
  output logic clk_out,
  output logic [1:0] sel_cur,
  output logic busy
);

  typedef enum logic [1:0] {
    GM_RUN = 2'b00,
    GM_DRAIN = 2'b01,
    GM_ARM = 2'b10
  } lpcsm_gm_state_t;

  lpcsm_gm_state_t state_r;

  // Old source is followed until it falls, so its high phase is never cut;
  // the new one is taken only once it is low, so its first high is whole.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_r <= GM_RUN;
      sel_cur <= RESET_SEL;
    end
    else
    begin
      case (state_r)
        GM_RUN:
          if (sel_req != sel_cur)
            state_r <= GM_DRAIN;
        GM_DRAIN:
          if (!src_levels[sel_cur])
          begin
            sel_cur <= sel_req; // R24
            state_r <= GM_ARM;
          end
        GM_ARM:
          if (!src_levels[sel_cur])
            state_r <= GM_RUN; // R24
        default:
          state_r <= GM_RUN;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      clk_out <= 1'b0;
    else if (state_r == GM_ARM)
      clk_out <= 1'b0; // R24
    else if (state_r == GM_DRAIN && !src_levels[sel_cur])
      clk_out <= 1'b0;
    else
      clk_out <= src_levels[sel_cur];
  end

  assign busy = (state_r != GM_RUN);

endmodule

// ===== rtl/lpcsm_pkg.sv
// Package of constants and decode functions for the line port clock mux
// Notes on behaviour
// R1 - Loop timing: transmit clocked like receive
// R2 - Loop timing: loopbacks never move clock sources
// R3 - Loop timing, unit active: recovered clock everywhere
// R4 - Loop timing, unit inactive: line clock pin everywhere
// R5 - Without loop timing, loopbacks switch clock sources
// R6 - Line loopback: line clock out from receive side
// R7 - Payload loopback: transmit clocks follow receive side
// R8 - Payload loopback ignores transmit framer inputs
// R9 - Diagnostic loopback: receive clocked from transmit source
// R10 - Diagnostic loopback ignores receive line data
// R11 - Diagnostic plus line: split line and receive clocks
// R12 - Receive default: recovered clock or line pin
// R13 - Transmit default: rate adapter unless choice set
// R14 - Unit active decoded from line mode 001-011
// R15 - Other loopbacks: line clock out from transmit choice
// R16 - External logic times pins to matching clocks
// R17 - Loop timed, unit active: use receive clock out
// R18 - Loop timed, unit inactive: use line clock in
// R19 - Line loopback: time transmit line to its clock
// R20 - Diagnostic loopback: time framer to receive clock
// R21 - Loopback codes: 1XX diagnostic, 001 analog
// R22 - Transmit clock out source selection
// R23 - Receive clock out source selection
// R24 - Source changes make no runt clock pulses
package lpcsm_pkg;

  // Clock source codes, also shown in the status register
  localparam logic [1:0] SRC_LIU = 2'h0;
  localparam logic [1:0] SRC_RX_LINE_CLOCK_IN = 2'h1;
  localparam logic [1:0] SRC_CLOCK_RATE_ADAPTER = 2'h2;
  localparam logic [1:0] SRC_TX_CLOCK_IN = 2'h3;
  localparam int NUM_SRC = 4;
  localparam int NUM_OUT = 3;
  localparam int OUT_RX = 0;
  localparam int OUT_TX = 1;
  localparam int OUT_TL = 2;

  // Loopback mode codes
  localparam logic [2:0] LBM_NONE = 3'h0;
  localparam logic [2:0] LBM_ANALOG = 3'h1;
  localparam logic [2:0] LBM_LINE = 3'h2;
  localparam logic [2:0] LBM_PAYLOAD = 3'h3;
  localparam logic [2:0] LBM_DIAG_LINE = 3'h6;
  localparam int LBM_DIAG_BIT = 2;

  // Register byte addresses
  localparam logic [7:0] ADDR_CFG3 = 8'h00;
  localparam logic [7:0] ADDR_CFG4 = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // Field positions of port_config_reg_three
  localparam int CFG3_LOOP_TIMING_ENABLE = 0;
  localparam int CFG3_CHOICE = 1;
  localparam int CFG3_RX_FRAMER_TIMING_SELECT = 2;
  localparam int CFG3_TX_LINE_TIMING_SELECT = 3;
  localparam int CFG3_TX_FRAMER_TIMING_SELECT = 4;
  // Field positions of port_config_reg_four
  localparam int CFG4_LM_LSB = 0;
  localparam int CFG4_LBM_LSB = 4;
  // Field positions of the status register
  localparam int ST_RXSRC_LSB = 0;
  localparam int ST_TXSRC_LSB = 2;
  localparam int ST_TLSRC_LSB = 4;
  localparam int ST_ACTIVE = 6;
  localparam int ST_BUSY = 7;
  localparam int ST_PRESENT_LSB = 8;

  // Reset values
  localparam logic [2:0] LM_RESET = 3'h0;
  localparam logic [2:0] LBM_RESET = 3'h0;
  localparam logic CFG_BIT_RESET = 1'b0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // A source is counted missing after this long without a rising edge
  localparam int SYS_CLK_MHZ = 25;
  localparam int LOSS_TIME_NS = 2000;
  localparam int LOSS_CYC = (LOSS_TIME_NS * SYS_CLK_MHZ) / 1000;
  localparam int CNT_W = 8;

  function automatic logic unit_active(input logic [2:0] lm);
    unit_active = (lm == 3'h1) || (lm == 3'h2) || (lm == 3'h3); // R14
  endfunction

  function automatic logic is_diag(input logic [2:0] lbm);
    is_diag = lbm[LBM_DIAG_BIT]; // R21
  endfunction

endpackage

// ===== rtl/lpcsm_sync.sv
// Two flip-flop synchroniser for levels from outside the sys_clk domain
module lpcsm_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1_r;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      stage1_r <= '0;
      dout <= '0;
    end
    else
    begin
      stage1_r <= din;
      dout <= stage1_r;
    end
  end

endmodule
